// file: uart_rx_pkg.sv
// constants, types and helpers shared by the receive path
// Notes on behaviour
// - complete flag is one while the buffer holds an unread character, else zero
// - dropping the receiver enable empties the buffer and clears the complete flag
// - with its enable set, the interrupt request follows the complete flag and global enable
// - error flags travel with their character; status shows the oldest unread entry
// - status writes never touch the error flags; error flags raise no interrupt
// - framing error flag is one when the first stop bit was received low
// - only the first stop bit is examined, whatever the stop-bit count setting
// - overrun is marked when buffer is full, shift register holds one, new start seen
// - overrun mark clears when a character moves from shift register into buffer
// - with parity checking off the parity error flag reads zero
// - checker runs only with the upper parity bit set; lower bit picks odd or even
// - checker compares data parity with the parity bit and stores the result with data
// - parity error shows for the oldest unread character checked with parity on
// - dropping the enable stops reception at once and releases the receive pin
// - the line is sampled 16 times per bit, or 8 times in double speed
// - start detection begins on a high-to-low edge; first low sample is sample one
// - start bit is judged by samples 8, 9, 10, or 4, 5, 6 in double speed
// - two or more high voting samples reject the start bit and watching resumes
// - each valid start bit realigns the bit sampling phase
// - every data and parity bit and the first stop bit takes the majority of its three centre samples
// - data bits above the character size read as zero
// - a ninth data bit is stored per entry and shown in the second control register
package uart_rx_pkg;

   // byte addresses on the bus
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_CSA = 8'h04;
   localparam logic [7:0] ADDR_CSB = 8'h08;
   localparam logic [7:0] ADDR_CSC = 8'h0C;
   localparam logic [7:0] ADDR_BAUD = 8'h10;

   // first status register bits
   localparam int CSA_RXC = 7;
   localparam int CSA_FE = 4;
   localparam int CSA_DOR = 3;
   localparam int CSA_PE = 2;
   localparam int CSA_DSEL = 1;
   // second control register bits
   localparam int CSB_RX_COMPLETE_IRQ_ENABLE = 7;
   localparam int CSB_RECEIVER_ENABLE = 4;
   localparam int CSB_SIZE2 = 2;
   localparam int CSB_NINTH = 1;
   // third control register bits
   localparam int CSC_PEN = 5;
   localparam int CSC_PODD = 4;
   localparam int CSC_STOP = 3;
   localparam int CSC_SIZE_LO = 1;

   // reset values and the nine-bit size code
   localparam logic [2:0] SIZE_RESET = 3'h3;
   localparam logic [11:0] BAUD_RESET = 12'h000;
   localparam logic [2:0] SIZE_NINE = 3'h7;

   // oversampling figures
   localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
   localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
   localparam logic [4:0] VOTE_NORMAL = 5'h08;
   localparam logic [4:0] VOTE_DOUBLE = 5'h04;
   localparam logic [4:0] VOTE_SPAN = 5'h02;
   localparam logic [1:0] VOTE_MAJORITY = 2'h2;

   typedef struct packed {
      logic [8:0] data;
      logic framing_err;
      logic parity_err;
   } frame_t;

   typedef struct packed {
      logic [8:0] data;
      logic framing_err;
      logic overrun;
      logic parity_err;
   } entry_t;

   // number of data bits for a size code, 5 to 9
   function automatic logic [3:0] data_bit_count(input logic [2:0] size);
      logic [3:0] n;
      n = 4'h8;
      if (size == SIZE_NINE) begin
         n = 4'h9;
      end else if (size < 3'h4) begin
         n = {2'b01, size[1:0]} + 4'h1;
      end
      return n;
   endfunction : data_bit_count

   // keeps only the configured number of data bits
   function automatic logic [8:0] size_mask(input logic [2:0] size);
      logic [8:0] m;
      m = 9'h1FF >> (4'h9 - data_bit_count(size));
      return m;
   endfunction : size_mask

endpackage : uart_rx_pkg

// file: rx_sampler.sv
// oversampling start detection and bit recovery
`timescale 1ns/10ps
module rx_sampler
   import uart_rx_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // configuration
   input wire logic enable,
   input wire logic double_speed,
   input wire logic [3:0] nbits,
   input wire logic parity_en,
   input wire logic parity_odd,
   // sample tick and synchronised line
   input wire logic tick,
   input wire logic rxd,
   // results
   output logic start_ok,
   output logic frame_valid,
   output frame_t frame
);

   typedef enum logic [2:0] {IDLE, START, DATA, PARITY, STOP} phase_t;

   typedef struct packed {
      phase_t phase;
      logic prev;
      logic [4:0] cnt;
      logic [1:0] highs;
      logic [3:0] bitidx;
      logic [8:0] shift;
      logic par_acc;
      logic par_bit;
      logic start_ok;
      logic frame_valid;
      frame_t frame;
   } samp_state_t;

   samp_state_t r_reg;
   samp_state_t r_next;

   always_comb begin
      logic [4:0] nc;
      logic [4:0] per_bit;
      logic [4:0] vfirst;
      logic [1:0] h;
      logic bitv;
      logic decide;
      nc = r_reg.cnt + 5'h1;
      per_bit = double_speed ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
      vfirst = double_speed ? VOTE_DOUBLE : VOTE_NORMAL;
      h = r_reg.highs;
      bitv = 1'b0;
      decide = 1'b0;
      r_next = r_reg;
      r_next.start_ok = 1'b0;
      r_next.frame_valid = 1'b0;
      if (tick && r_reg.phase != IDLE) begin
         r_next.cnt = nc;
         if (nc >= vfirst && nc <= vfirst + VOTE_SPAN) begin
            h = r_reg.highs + {1'b0, rxd};
            r_next.highs = h;
         end
         decide = (nc == vfirst + VOTE_SPAN);
         bitv = (h >= VOTE_MAJORITY);
      end
      if (tick) begin
         unique case (r_reg.phase)
            IDLE: begin
               r_next.prev = rxd;
               if (r_reg.prev && !rxd) begin
                  r_next.phase = START;
                  r_next.cnt = 5'h1;
                  r_next.highs = 2'h0;
                  r_next.shift = 9'h000;
                  r_next.par_acc = 1'b0;
               end
            end
            START: begin
               if (decide && bitv) begin
                  r_next.phase = IDLE;
                  r_next.prev = rxd;
               end else if (decide) begin
                  r_next.start_ok = 1'b1;
               end
               if (nc == per_bit) begin
                  r_next.phase = DATA;
                  r_next.cnt = 5'h0;
                  r_next.highs = 2'h0;
                  r_next.bitidx = 4'h0;
               end
            end
            DATA: begin
               if (decide) begin
                  r_next.shift[r_reg.bitidx] = bitv;
                  r_next.par_acc = r_reg.par_acc ^ bitv;
               end
               if (nc == per_bit) begin
                  r_next.cnt = 5'h0;
                  r_next.highs = 2'h0;
                  if (r_reg.bitidx == nbits - 4'h1) begin
                     r_next.phase = parity_en ? PARITY : STOP;
                  end else begin
                     r_next.bitidx = r_reg.bitidx + 4'h1;
                  end
               end
            end
            PARITY: begin
               if (decide) begin
                  r_next.par_bit = bitv;
               end
               if (nc == per_bit) begin
                  r_next.phase = STOP;
                  r_next.cnt = 5'h0;
                  r_next.highs = 2'h0;
               end
            end
            STOP: begin
               // frame ends at the first stop bit's vote so a new start may follow
               if (decide) begin
                  r_next.phase = IDLE;
                  r_next.prev = rxd;
                  r_next.frame_valid = 1'b1;
                  r_next.frame.data = r_reg.shift;
                  r_next.frame.framing_err = !bitv;
                  r_next.frame.parity_err = parity_en &&
                     (r_reg.par_acc ^ r_reg.par_bit ^ parity_odd);
               end
            end
         endcase
      end
      if (!enable) begin
         r_next.phase = IDLE;
         r_next.prev = 1'b0;
         r_next.start_ok = 1'b0;
         r_next.frame_valid = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign start_ok = r_reg.start_ok;
   assign frame_valid = r_reg.frame_valid;
   assign frame = r_reg.frame;

endmodule : rx_sampler

// file: rx_buffer.sv
// two-entry receive buffer holding each character with its status
`timescale 1ns/10ps
module rx_buffer
   import uart_rx_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire logic flush,
   input wire logic push,
   input entry_t push_entry,
   input wire logic pop,
   // state
   output entry_t head,
   output logic [1:0] count
);

   typedef struct packed {
      entry_t [1:0] mem;
      logic rd;
      logic [1:0] count;
   } buf_state_t;

   buf_state_t r_reg;
   buf_state_t r_next;

   always_comb begin
      logic do_pop;
      logic do_push;
      logic wr;
      do_pop = pop && (r_reg.count != 2'h0);
      do_push = push && (r_reg.count != 2'h2 || do_pop);
      // tail slot; when full it is only written through a pop that frees the head
      wr = r_reg.rd ^ r_reg.count[0];
      r_next = r_reg;
      if (do_push) begin
         r_next.mem[wr] = push_entry;
      end
      if (do_pop) begin
         r_next.rd = !r_reg.rd;
      end
      r_next.count = r_reg.count + {1'b0, do_push} - {1'b0, do_pop};
      if (flush) begin
         r_next.count = 2'h0;
         r_next.rd = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign head = r_reg.mem[r_reg.rd];
   assign count = r_reg.count;

endmodule : rx_buffer

// file: uart_receive_path.sv
// receive path top: bus slave, sample tick, line sync, overrun and holding logic
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module uart_receive_path
   import uart_rx_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial line and pin control
   input wire logic rxd_pin,
   output logic rxd_override,
   // interrupt
   input wire logic global_irq_enable,
   output logic rx_irq
);

   typedef struct packed {
      logic rxd_meta;
      logic rxd_sync;
      logic double_speed_select;
      logic rx_complete_irq_enable;
      logic receiver_enable;
      logic [2:0] char_size_select;
      logic parity_enable_bit;
      logic parity_odd_select;
      logic stop_bit_count_select;
      logic [11:0] baud_div;
      logic [11:0] baud_cnt;
      logic tick;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
      logic pend_valid;
      entry_t pend;
      logic ovr;
   } top_state_t;

   top_state_t r_reg;
   top_state_t r_next;

   logic start_ok;
   logic frame_valid;
   frame_t frame;
   entry_t head;
   logic [1:0] count;
   logic push;
   entry_t push_entry;
   logic pop;
   logic rx_complete_flag;
   logic buf_full;

   assign rx_complete_flag = (count != 2'h0);
   assign buf_full = (count == 2'h2);

   rx_sampler u_sampler (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(r_reg.receiver_enable),
      .double_speed(r_reg.double_speed_select),
      .nbits(data_bit_count(r_reg.char_size_select)),
      .parity_en(r_reg.parity_enable_bit),
      .parity_odd(r_reg.parity_odd_select),
      .tick(r_reg.tick),
      .rxd(r_reg.rxd_sync),
      .start_ok(start_ok),
      .frame_valid(frame_valid),
      .frame(frame)
   );

   rx_buffer u_buffer (
      .hclk(hclk),
      .hresetn(hresetn),
      .flush(!r_reg.receiver_enable),
      .push(push),
      .push_entry(push_entry),
      .pop(pop),
      .head(head),
      .count(count)
   );

   always_comb begin
      logic take;
      logic [31:0] rd;
      logic [8:0] shown;
      logic ovr_set;
      entry_t incoming;
      take = hsel && htrans[1] && hready;
      ovr_set = start_ok && buf_full && r_reg.pend_valid;
      rd = 32'h0000_0000;
      shown = head.data & size_mask(r_reg.char_size_select);
      incoming = '{data: frame.data, framing_err: frame.framing_err,
                   overrun: r_reg.ovr, parity_err: frame.parity_err};
      r_next = r_reg;
      push = 1'b0;
      push_entry = incoming;
      pop = 1'b0;

      // two flops before anything looks at the line
      r_next.rxd_meta = rxd_pin;
      r_next.rxd_sync = r_reg.rxd_meta;

      // sample tick: one pulse every baud_div + 1 clocks
      r_next.tick = 1'b0;
      if (r_reg.baud_cnt == 12'h000) begin
         r_next.baud_cnt = r_reg.baud_div;
         r_next.tick = 1'b1;
      end else begin
         r_next.baud_cnt = r_reg.baud_cnt - 12'h001;
      end

      // address phase; read data is captured here so a data read pops at once
      r_next.ap_valid = take;
      r_next.ap_write = hwrite;
      r_next.ap_addr = haddr;
      if (take && !hwrite) begin
         unique case (haddr)
            ADDR_DATA: begin
               rd[7:0] = shown[7:0];
               pop = rx_complete_flag;
            end
            ADDR_CSA: begin
               rd[CSA_RXC] = rx_complete_flag;
               if (rx_complete_flag) begin
                  rd[CSA_FE] = head.framing_err;
                  rd[CSA_DOR] = head.overrun;
                  rd[CSA_PE] = head.parity_err && r_reg.parity_enable_bit;
               end
               rd[CSA_DSEL] = r_reg.double_speed_select;
            end
            ADDR_CSB: begin
               rd[CSB_RX_COMPLETE_IRQ_ENABLE] = r_reg.rx_complete_irq_enable;
               rd[CSB_RECEIVER_ENABLE] = r_reg.receiver_enable;
               rd[CSB_SIZE2] = r_reg.char_size_select[2];
               rd[CSB_NINTH] = rx_complete_flag && shown[8];
            end
            ADDR_CSC: begin
               rd[CSC_PEN] = r_reg.parity_enable_bit;
               rd[CSC_PODD] = r_reg.parity_odd_select;
               rd[CSC_STOP] = r_reg.stop_bit_count_select;
               rd[CSC_SIZE_LO +: 2] = r_reg.char_size_select[1:0];
            end
            ADDR_BAUD: begin
               rd[11:0] = r_reg.baud_div;
            end
            default: begin
               rd = 32'h0000_0000;
            end
         endcase
         r_next.hrdata = rd;
      end

      // data phase of a write
      if (r_reg.ap_valid && r_reg.ap_write) begin
         unique case (r_reg.ap_addr)
            ADDR_CSA: begin
               // error flags live in the buffer and are not writable
               r_next.double_speed_select = hwdata[CSA_DSEL];
            end
            ADDR_CSB: begin
               r_next.rx_complete_irq_enable = hwdata[CSB_RX_COMPLETE_IRQ_ENABLE];
               r_next.receiver_enable = hwdata[CSB_RECEIVER_ENABLE];
               r_next.char_size_select[2] = hwdata[CSB_SIZE2];
            end
            ADDR_CSC: begin
               r_next.parity_enable_bit = hwdata[CSC_PEN];
               r_next.parity_odd_select = hwdata[CSC_PODD];
               r_next.stop_bit_count_select = hwdata[CSC_STOP];
               r_next.char_size_select[1:0] = hwdata[CSC_SIZE_LO +: 2];
            end
            ADDR_BAUD: begin
               r_next.baud_div = hwdata[11:0];
            end
            default: begin
               r_next.baud_div = r_reg.baud_div;
            end
         endcase
      end

      // the held character moves first; a frame finishing meanwhile is held
      if (r_reg.pend_valid && (!buf_full || pop)) begin
         push = 1'b1;
         push_entry = r_reg.pend;
         push_entry.overrun = r_reg.ovr;
         r_next.pend_valid = frame_valid;
         r_next.pend = incoming;
      end else if (frame_valid && !r_reg.pend_valid && (!buf_full || pop)) begin
         push = 1'b1;
      end else if (frame_valid && !r_reg.pend_valid) begin
         r_next.pend_valid = 1'b1;
         r_next.pend = incoming;
      end
      // a frame arriving while one is already held is lost; the overrun marks it
      r_next.ovr = (r_reg.ovr && !push) || ovr_set;

      if (!r_reg.receiver_enable) begin
         r_next.pend_valid = 1'b0;
         r_next.ovr = 1'b0;
         push = 1'b0;
         pop = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.rxd_meta <= 1'b1;
         r_reg.rxd_sync <= 1'b1;
         r_reg.char_size_select <= SIZE_RESET;
         r_reg.baud_div <= BAUD_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign hrdata = r_reg.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rxd_override = r_reg.receiver_enable;
   // error flags do not take part in the request
   assign rx_irq = r_reg.rx_complete_irq_enable && rx_complete_flag
      && global_irq_enable;

endmodule : uart_receive_path

// file: rx_path_asserts.sv
// concurrent checks on the receive path ports
`timescale 1ns/10ps
module rx_path_asserts
   import uart_rx_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // serial line and pin control
   input wire logic rxd_pin,
   input wire logic rxd_override,
   // interrupt
   input wire logic global_irq_enable,
   input wire logic rx_irq
);
   logic take, rd_take, rd_csa, wcsb, wr_reg, par_on_reg;
   logic [7:0] addr_reg;
   assign take = hsel && htrans[1] && hready;
   assign rd_take = take && !hwrite;
   assign rd_csa = rd_take && haddr == ADDR_CSA;
   // write data only stands in the data phase, so the address is kept a cycle
   assign wcsb = wr_reg && addr_reg == ADDR_CSB;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         par_on_reg <= 1'b0;
      end else begin
         wr_reg <= take && hwrite;
         addr_reg <= haddr;
         if (wr_reg && addr_reg == ADDR_CSC) begin
            par_on_reg <= hwdata[CSC_PEN];
         end
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("response not okay");
   ready_high_a: assert property (hreadyout)
      else $error("wait state inserted");
   irq_gated_a: assert property (!global_irq_enable |-> !rx_irq)
      else $error("request without global enable");
   irq_flag_a: assert property (rd_csa && rx_irq |=> hrdata[CSA_RXC])
      else $error("request while complete flag reads zero");
   pin_release_a: assert property (wcsb && !hwdata[CSB_RECEIVER_ENABLE] |-> ##[1:2] !rxd_override)
      else $error("pin kept after disable");
   pin_take_a: assert property (wcsb && hwdata[CSB_RECEIVER_ENABLE] |-> ##[1:2] rxd_override)
      else $error("pin not taken after enable");
   flush_irq_a: assert property (!rxd_override [*2] |-> !rx_irq)
      else $error("buffer not flushed when disabled");
   parity_off_a: assert property (rd_csa && !par_on_reg |=> !hrdata[CSA_PE])
      else $error("parity error with checking off");
   hold_rdata_a: assert property ($changed(hrdata) |-> $past(rd_take))
      else $error("read data moved without a read");
   cover property (rd_csa ##1 hrdata[CSA_DOR]);
   cover property (rd_csa ##1 hrdata[CSA_PE]);
   cover property ($fell(rxd_override));
endmodule : rx_path_asserts

bind uart_receive_path rx_path_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .rxd_pin(rxd_pin), .rxd_override(rxd_override),
   .global_irq_enable(global_irq_enable), .rx_irq(rx_irq));

// file: serial_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/10ps
module serial_tx_model (
   // clock
   input wire logic hclk,
   // serial line, idle high
   output logic line
);
   initial line = 1'b1;
   // bits lsb first from the start bit; glitch flips one clock at each bit edge
   task automatic send(input logic [12:0] bits, input int n, input int len, input bit glitch);
      for (int i = 0; i < n; i++) begin
         for (int c = 0; c < len; c++) begin
            @(posedge hclk);
            line <= (glitch && c == 0) ? ~bits[i] : bits[i];
         end
      end
      @(posedge hclk);
      line <= 1'b1;
   endtask : send
   // short low pulse, too brief for a start bit
   task automatic spike(input int len);
      @(posedge hclk);
      line <= 1'b0;
      repeat (len) @(posedge hclk);
      line <= 1'b1;
   endtask : spike
endmodule : serial_tx_model

// file: tb.sv
// self-checking bench for the receive path
`timescale 1ns/10ps
module tb;
   import uart_rx_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rxd_pin, rxd_override;
   logic global_irq_enable, rx_irq, ds, st, bp, bs, gie, gl;
   logic [7:0] haddr;
   logic [1:0] htrans, pm;
   logic [2:0] hsize, code;
   logic [31:0] hwdata, hrdata, r, e;
   logic [8:0] dd [0:3];
   int failures, checks, nd, len;
   integer seed = 32'hed48;

   uart_receive_path dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_pin(rxd_pin),
      .rxd_override(rxd_override), .global_irq_enable(global_irq_enable), .rx_irq(rx_irq));
   serial_tx_model tx_u (.hclk(hclk), .line(rxd_pin));

   function automatic logic [12:0] build(input logic [8:0] d, input int n, input logic [1:0] m,
         input logic bad_p, input logic bad_s);
      logic [12:0] b;
      b = 13'h1FFF;
      b[0] = 1'b0;
      for (int i = 0; i < n; i++) begin
         b[i + 1] = d[i];
      end
      if (m[1]) begin
         b[n + 1] = ^(d & ((9'h1 << n) - 9'h1)) ^ m[0] ^ bad_p;
      end
      b[n + 1 + m[1]] = ~bad_s;
      return b;
   endfunction : build

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, x);
   endtask : rd

   // pins looked at between edges, leaving one edge for a flush to land
   task automatic pin(input bit sel, input logic x);
      repeat (2) @(negedge hclk);
      chk({31'h0, sel ? rxd_override : rx_irq}, {31'h0, x});
      @(posedge hclk);
   endtask : pin

   task automatic wait_rx();
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, ADDR_CSA, 32'h0, q);
         n++;
      end while (q[CSA_RXC] !== 1'b1 && n < 40);
   endtask : wait_rx

   task automatic report_and_stop();
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   initial begin
      repeat (40000) @(posedge hclk);
      failures++;
      report_and_stop();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      global_irq_enable = 1'b1;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ADDR_CSC, 32'h6);
      rd(8'h20, 32'h0);
      wr(ADDR_BAUD, 32'h1);
      rd(ADDR_BAUD, 32'h1);
      // size codes 0 to 3, 5 and 7, every parity mode, random data, line and error choices
      for (int i = 0; i < 15; i++) begin
         r = $random(seed);
         nd = 5 + i % 5;
         pm = 2'(i % 4);
         {gl, gie, bp, ds} = {r[14:13], r[11], r[9]};
         st = r[10] | (i == 3);
         bs = r[12] | (i == 3);
         code = (nd == 9) ? 3'h7 : (nd == 8 && r[15]) ? 3'h5 : 3'(nd - 5);
         len = ds ? 16 : 32;
         wr(ADDR_CSA, {30'h0, ds, 1'b0});
         wr(ADDR_CSB, {24'h0, 5'h12, code[2], 2'h0});
         wr(ADDR_CSC, {26'h0, pm, st, code[1:0], 1'b0});
         global_irq_enable <= gie;
         tx_u.send(build(r[8:0], nd, pm, bp, bs), nd + 2 + pm[1] + st, len, gl);
         wait_rx();
         pin(1'b0, gie);
         e = {24'h0, 1'b1, 2'h0, bs, 1'b0, pm[1] & bp, ds, 1'b0};
         rd(ADDR_CSA, e);
         wr(ADDR_CSA, {30'h0, ds, 1'b0});
         rd(ADDR_CSA, e);
         rd(ADDR_CSB, {24'h0, 5'h12, code[2], nd == 9 && r[8], 1'b0});
         rd(ADDR_DATA, {24'h0, r[7:0] & ~(8'hFF << nd)});
         rd(ADDR_CSA, {30'h0, ds, 1'b0});
         pin(1'b0, 1'b0);
      end
      // four frames back to back with no reads in between
      wr(ADDR_CSA, 32'h0);
      wr(ADDR_CSB, 32'h90);
      wr(ADDR_CSC, 32'h6);
      global_irq_enable <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         dd[k] = 9'($random(seed));
         tx_u.send(build(dd[k], 8, 2'h0, 1'b0, 1'b0), 10, 32, 1'b0);
      end
      for (int k = 0; k < 3; k++) begin
         rd(ADDR_CSA, (k == 2) ? 32'h88 : 32'h80);
         rd(ADDR_DATA, {24'h0, dd[k][7:0]});
      end
      rd(ADDR_CSA, 32'h0);
      tx_u.spike(6);
      repeat (64) @(posedge hclk);
      rd(ADDR_CSA, 32'h0);
      tx_u.send(build(dd[3], 8, 2'h0, 1'b0, 1'b0), 10, 32, 1'b0);
      wait_rx();
      rd(ADDR_CSA, 32'h80);
      rd(ADDR_DATA, {24'h0, dd[3][7:0]});
      // disable with a full buffer, then in mid-frame
      repeat (2) tx_u.send(build(dd[0], 8, 2'h0, 1'b0, 1'b0), 10, 32, 1'b0);
      wait_rx();
      pin(1'b0, 1'b1);
      wr(ADDR_CSB, 32'h80);
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
      wr(ADDR_CSB, 32'h90);
      rd(ADDR_CSA, 32'h0);
      pin(1'b1, 1'b1);
      fork
         tx_u.send(build(9'hFF, 8, 2'h0, 1'b0, 1'b0), 10, 32, 1'b0);
         begin
            repeat (100) @(posedge hclk);
            wr(ADDR_CSB, 32'h80);
            wr(ADDR_CSB, 32'h90);
         end
      join
      repeat (40) @(posedge hclk);
      rd(ADDR_CSA, 32'h0);
      report_and_stop();
   end
endmodule : tb
